// ==== core/mss_pkg.sv ====
/*
  Shared constants and carrier types for the motion module status word bank.
  Assumes a single 200 MHz clock domain; word offsets are relative to the
  first word allocated to the motion module in the host's exchange area.
*/
package mss_pkg;

	// Word offsets inside the cyclic exchange area
	localparam logic [3:0] OFS_DIN_UPPER  = 4'h3;
	localparam logic [3:0] OFS_DOUT_UPPER = 4'h4;
	localparam logic [3:0] OFS_AXIS_LOW   = 4'h5;

	// Word geometry
	localparam int WORD_W   = 16;
	localparam int AXES     = 2;
	localparam int AXIS_W   = 8;

	// Flag positions within one axis byte
	localparam int BIT_FE_WARN  = 0;
	localparam int BIT_FWD_LIM  = 1;
	localparam int BIT_REV_LIM  = 2;
	localparam int BIT_HOMING   = 3;
	localparam int BIT_FEEDHOLD = 4;
	localparam int BIT_FE_LIM   = 5;
	localparam int BIT_SW_FWD   = 6;
	localparam int BIT_SW_REV   = 7;

	// Reset value of every held word and the value of unmapped reads
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [15:0] RD_UNMAPPED = 16'h0000;

	// Per-axis state delivered by the motion core
	typedef struct packed {
		logic signed [31:0] position;
		logic signed [31:0] sw_fwd_lim;
		logic signed [31:0] sw_rev_lim;
		logic        [15:0] ferr_mag;
		logic        [15:0] ferr_warn;
		logic        [15:0] ferr_hard;
		logic               homing;
		logic               feedhold;
	} mss_axis_in_type;

	// One coherent set of status words
	typedef struct packed {
		logic [15:0] din_word;
		logic [15:0] dout_word;
		logic [15:0] axis_word;
	} mss_words_type;

endpackage

// ==== core/mss_status_words.sv ====
/*
  Status word bank of the motion module: digital input and output status
  and the axis 0/1 flag word, captured coherently at each host I/O refresh.
  Assumes digital input pins and limit switch pins are asynchronous, while
  axis data, output states and the host refresh/read strobes are on clk.
*/
`timescale 1ns/1ps
// Summary of operation
// - Every host I/O refresh strobe taken with ce high copies the status words to the host side with no other request.
// - The words only flow from the module to the host; the host can read but never write them.
// - Bits 0 to 15 of the input status word mirror digital inputs 8 to 23 in ascending order.
// - Bits 0 to 15 of the output status word mirror digital outputs 8 to 23 in ascending order.
// - An axis flag at bit 0 (axis 0) or bit 8 (axis 1) is set when following error passes its warning limit.
// - An axis flag at bit 1 or bit 9 is set while that axis's forward limit is active.
// - An axis flag at bit 2 or bit 10 is set while that axis's reverse limit is active.
// - An axis flag at bit 3 or bit 11 stays set while a homing search runs on that axis.
// - An axis flag at bit 4 or bit 12 is set while a feed hold is applied to that axis.
// - An axis flag at bit 5 or bit 13 is set when following error passes its hard limit.
// - An axis flag at bit 6 or bit 14 is set when position is beyond the software forward limit.
// - An axis flag at bit 7 or bit 15 is set when position is beyond the software reverse limit.
module mss_status_words (
	// Clock, reset, enable
	input  wire logic                                          clk,
	input  wire logic                                          sys_rst,
	input  wire logic                                          ce,
	// Field pins, asynchronous
	input  wire logic [15:0]                                   din_pins,
	input  wire logic [mss_pkg::AXES-1:0]                      fwd_lim_pins,
	input  wire logic [mss_pkg::AXES-1:0]                      rev_lim_pins,
	// Motion core state, same clock
	input  wire logic [15:0]                                   dout_state,
	input  wire mss_pkg::mss_axis_in_type [mss_pkg::AXES-1:0]  axis_in,
	// Host exchange port
	input  wire logic                                          refresh_req,
	input  wire logic                                          rd_req,
	input  wire logic [3:0]                                    rd_addr,
	input  wire logic                                          wr_req,
	// Held status words and host answers
	output logic [15:0]                                        din_word_reg,
	output logic [15:0]                                        dout_word_reg,
	output logic [15:0]                                        axis_word_reg,
	output logic                                               refresh_ack_reg,
	output logic [15:0]                                        rd_data_reg,
	output logic                                               rd_valid_reg,
	output logic                                               wr_refused_reg
);

	localparam int NAX = mss_pkg::AXES;
	localparam int AW  = mss_pkg::AXIS_W;

	// Synchroniser stages for field pins
	logic [15:0]    din_meta_reg;
	logic [15:0]    din_meta_next;
	logic [15:0]    din_sync_reg;
	logic [15:0]    din_sync_next;
	logic [NAX-1:0] fwd_meta_reg;
	logic [NAX-1:0] fwd_meta_next;
	logic [NAX-1:0] fwd_sync_reg;
	logic [NAX-1:0] fwd_sync_next;
	logic [NAX-1:0] rev_meta_reg;
	logic [NAX-1:0] rev_meta_next;
	logic [NAX-1:0] rev_sync_reg;
	logic [NAX-1:0] rev_sync_next;

	// Live words, one sample per cycle
	mss_pkg::mss_words_type live_reg;
	mss_pkg::mss_words_type live_next;
	logic [15:0]            axis_flags;

	// Held words and host answers
	logic [15:0] din_word_next;
	logic [15:0] dout_word_next;
	logic [15:0] axis_word_next;
	logic        refresh_ack_next;
	logic [15:0] rd_data_next;
	logic        rd_valid_next;
	logic        wr_refused_next;

	// Two-flop synchronisers; first stage feeds only the second
	always_comb begin
		din_meta_next = din_pins;
		din_sync_next = din_meta_reg;
		fwd_meta_next = fwd_lim_pins;
		fwd_sync_next = fwd_meta_reg;
		rev_meta_next = rev_lim_pins;
		rev_sync_next = rev_meta_reg;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			din_meta_reg <= mss_pkg::WORD_RST;
			din_sync_reg <= mss_pkg::WORD_RST;
			fwd_meta_reg <= '0;
			fwd_sync_reg <= '0;
			rev_meta_reg <= '0;
			rev_sync_reg <= '0;
		end else if (ce) begin
			din_meta_reg <= din_meta_next;
			din_sync_reg <= din_sync_next;
			fwd_meta_reg <= fwd_meta_next;
			fwd_sync_reg <= fwd_sync_next;
			rev_meta_reg <= rev_meta_next;
			rev_sync_reg <= rev_sync_next;
		end
	end

	// Per-axis flag byte; conditions are levels, so absent means zero
	for (genvar a = 0; a < NAX; a++) begin : g_axis
		assign axis_flags[a*AW+mss_pkg::BIT_FE_WARN]  = axis_in[a].ferr_mag > axis_in[a].ferr_warn;
		assign axis_flags[a*AW+mss_pkg::BIT_FWD_LIM]  = fwd_sync_reg[a];
		assign axis_flags[a*AW+mss_pkg::BIT_REV_LIM]  = rev_sync_reg[a];
		assign axis_flags[a*AW+mss_pkg::BIT_HOMING]   = axis_in[a].homing;
		assign axis_flags[a*AW+mss_pkg::BIT_FEEDHOLD] = axis_in[a].feedhold;
		assign axis_flags[a*AW+mss_pkg::BIT_FE_LIM]   = axis_in[a].ferr_mag > axis_in[a].ferr_hard;
		assign axis_flags[a*AW+mss_pkg::BIT_SW_FWD]   = axis_in[a].position > axis_in[a].sw_fwd_lim;
		assign axis_flags[a*AW+mss_pkg::BIT_SW_REV]   = axis_in[a].position < axis_in[a].sw_rev_lim;
	end

	// Live sample of all three words in one register, one instant
	always_comb begin
		live_next.din_word  = din_sync_reg;
		live_next.dout_word = dout_state;
		live_next.axis_word = axis_flags;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			live_reg <= '0;
		end else if (ce) begin
			live_reg <= live_next;
		end
	end

	// Snapshot on refresh; host read and write strobes never alter the held words
	always_comb begin
		din_word_next    = din_word_reg;
		dout_word_next   = dout_word_reg;
		axis_word_next   = axis_word_reg;
		refresh_ack_next = refresh_req;
		wr_refused_next  = wr_req;
		if (refresh_req) begin
			din_word_next  = live_reg.din_word;
			dout_word_next = live_reg.dout_word;
			axis_word_next = live_reg.axis_word;
		end
	end

	// Read port returns the held words; unmapped offsets read zero
	always_comb begin
		rd_valid_next = rd_req;
		rd_data_next  = mss_pkg::RD_UNMAPPED;
		if (rd_req) begin
			case (rd_addr)
				mss_pkg::OFS_DIN_UPPER:  rd_data_next = din_word_reg;
				mss_pkg::OFS_DOUT_UPPER: rd_data_next = dout_word_reg;
				mss_pkg::OFS_AXIS_LOW:   rd_data_next = axis_word_reg;
				default:                 rd_data_next = mss_pkg::RD_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			din_word_reg    <= mss_pkg::WORD_RST;
			dout_word_reg   <= mss_pkg::WORD_RST;
			axis_word_reg   <= mss_pkg::WORD_RST;
			refresh_ack_reg <= 1'b0;
			wr_refused_reg  <= 1'b0;
			rd_data_reg     <= mss_pkg::WORD_RST;
			rd_valid_reg    <= 1'b0;
		end else if (ce) begin
			din_word_reg    <= din_word_next;
			dout_word_reg   <= dout_word_next;
			axis_word_reg   <= axis_word_next;
			refresh_ack_reg <= refresh_ack_next;
			wr_refused_reg  <= wr_refused_next;
			rd_data_reg     <= rd_data_next;
			rd_valid_reg    <= rd_valid_next;
		end
	end

	// Checks, all on clk with reset as the disable
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence seq_refresh;
		ce && refresh_req;
	endsequence

	sequence seq_quiet;
		ce && !refresh_req;
	endsequence

	// Host reads of the input and axis words; the multi-step check follows only the input word
	sequence seq_read_din;
		ce && rd_req && rd_addr == mss_pkg::OFS_DIN_UPPER;
	endsequence

	sequence seq_read_axis;
		ce && rd_req && rd_addr == mss_pkg::OFS_AXIS_LOW;
	endsequence

	sequence seq_idle_host;
		ce && !rd_req && !wr_req;
	endsequence

	AST_REFRESH_ACK: assert property (seq_refresh |=> refresh_ack_reg)
		else $error("refresh not acknowledged");

	AST_DIN_SNAP: assert property (seq_refresh |=> din_word_reg == $past(live_reg.din_word))
		else $error("input word not captured at refresh");

	AST_DOUT_PATH: assert property (ce ##1 seq_refresh |=> dout_word_reg == $past(dout_state, 2))
		else $error("output word does not follow output states");

	AST_DIN_PATH: assert property (ce [*3] ##1 seq_refresh |=> din_word_reg == $past(din_pins, 4))
		else $error("input word does not follow synchronised pins");

	// Refresh takes the live register, never the raw sources, so all three agree
	AST_COHERENT: assert property (seq_refresh |=>
		{din_word_reg, dout_word_reg, axis_word_reg} == $past(live_reg))
		else $error("words not taken from one sample");

	AST_HOLD_NO_REFRESH: assert property (seq_quiet |=>
		$stable(din_word_reg) && $stable(dout_word_reg) && $stable(axis_word_reg))
		else $error("held word changed without refresh");

	AST_WR_REFUSED: assert property (ce && wr_req && !refresh_req |=> wr_refused_reg && $stable(axis_word_reg))
		else $error("host write not refused");

	// Reads return the held words of the cycle before; a same-cycle refresh is not seen
	AST_RD_AXIS: assert property (seq_read_axis |=>
		rd_valid_reg && rd_data_reg == $past(axis_word_reg))
		else $error("axis word read mismatch");

	AST_RD_DIN: assert property (seq_read_din |=>
		rd_valid_reg && rd_data_reg == $past(din_word_reg))
		else $error("input word read mismatch");

	AST_RD_DOUT: assert property (ce && rd_req && rd_addr == mss_pkg::OFS_DOUT_UPPER |=>
		rd_valid_reg && rd_data_reg == $past(dout_word_reg))
		else $error("output word read mismatch");

	AST_RD_UNMAPPED: assert property (ce && rd_req && rd_addr > mss_pkg::OFS_AXIS_LOW |=>
		rd_valid_reg && rd_data_reg == mss_pkg::RD_UNMAPPED)
		else $error("unmapped read not zero");

	AST_RD_LOW: assert property (ce && rd_req && rd_addr < mss_pkg::OFS_DIN_UPPER |=>
		rd_valid_reg && rd_data_reg == mss_pkg::RD_UNMAPPED)
		else $error("read below the status words not zero");

	// Answers are one-cycle pulses; a stuck answer would fake a second access
	AST_ACK_PULSE: assert property (seq_quiet |=> !refresh_ack_reg)
		else $error("refresh acknowledge longer than one cycle");

	AST_RD_IDLE: assert property (seq_idle_host |=>
		!rd_valid_reg && !wr_refused_reg && rd_data_reg == mss_pkg::RD_UNMAPPED)
		else $error("read or write answer without a request");

	// Refresh, one quiet cycle, then a read: the host sees the sample of the refresh edge
	AST_REFRESH_READ: assert property (seq_refresh ##1 seq_quiet ##1 seq_read_din |=>
		rd_data_reg == $past(live_reg.din_word, 3))
		else $error("read behind a refresh returned a stale input word");

	// Live stage follows its sources with the documented latency
	AST_LIVE_DOUT: assert property (ce |=> live_reg.dout_word == $past(dout_state))
		else $error("live output word does not follow output states");

	AST_LIVE_DIN: assert property (ce ##1 ce ##1 ce |=> live_reg.din_word == $past(din_pins, 3))
		else $error("live input word does not follow synchronised pins");

	// Low enable freezes every stage, a refresh taken in that cycle included
	AST_FREEZE_HELD: assert property (!ce |=>
		$stable(din_word_reg) && $stable(dout_word_reg) && $stable(axis_word_reg) && $stable(refresh_ack_reg))
		else $error("held words moved while frozen");

	AST_FREEZE_LIVE: assert property (!ce |=> $stable(live_reg) && $stable(din_sync_reg))
		else $error("live sample moved while frozen");

	// Flag checks per axis, tied to raw conditions; equality covers both set and clear
	for (genvar k = 0; k < NAX; k++) begin : g_chk
		AST_FE_WARN: assert property (ce |=>
			live_reg.axis_word[k*AW+mss_pkg::BIT_FE_WARN] == $past(axis_in[k].ferr_mag > axis_in[k].ferr_warn))
			else $error("following error warning flag wrong");
		AST_FWD_LIM: assert property (ce ##1 ce ##1 ce |=>
			live_reg.axis_word[k*AW+mss_pkg::BIT_FWD_LIM] == $past(fwd_lim_pins[k], 3))
			else $error("forward limit flag wrong");
		AST_REV_LIM: assert property (ce ##1 ce ##1 ce |=>
			live_reg.axis_word[k*AW+mss_pkg::BIT_REV_LIM] == $past(rev_lim_pins[k], 3))
			else $error("reverse limit flag wrong");
		AST_HOMING: assert property (ce |=>
			live_reg.axis_word[k*AW+mss_pkg::BIT_HOMING] == $past(axis_in[k].homing))
			else $error("homing flag does not follow the search");
		AST_FEEDHOLD: assert property (ce |=>
			live_reg.axis_word[k*AW+mss_pkg::BIT_FEEDHOLD] == $past(axis_in[k].feedhold))
			else $error("feed hold flag wrong");
		AST_FE_LIM: assert property (ce |=>
			live_reg.axis_word[k*AW+mss_pkg::BIT_FE_LIM] == $past(axis_in[k].ferr_mag > axis_in[k].ferr_hard))
			else $error("following error limit flag wrong");
		AST_SW_FWD: assert property (ce |=>
			live_reg.axis_word[k*AW+mss_pkg::BIT_SW_FWD] == $past(axis_in[k].position > axis_in[k].sw_fwd_lim))
			else $error("software forward limit flag wrong");
		AST_SW_REV: assert property (ce |=>
			live_reg.axis_word[k*AW+mss_pkg::BIT_SW_REV] == $past(axis_in[k].position < axis_in[k].sw_rev_lim))
			else $error("software reverse limit flag wrong");
	end

endmodule

// ==== test/mss_host_model.sv ====
/*
  Host side of the status word bank: issues refresh, read and write strobes.
  Assumes the module answers on the taking edge, one cycle after the strobe is driven.
*/
`timescale 1ns/1ps
module mss_host_model (
	// Clock
	input  wire logic        clk,
	// Strobes toward the module
	output logic             refresh_req,
	output logic             rd_req,
	output logic [3:0]       rd_addr,
	output logic             wr_req,
	// Answers from the module
	input  wire logic        refresh_ack_reg,
	input  wire logic [15:0] rd_data_reg,
	input  wire logic        rd_valid_reg,
	input  wire logic        wr_refused_reg
);
	// Quiet bus at start
	initial begin
		refresh_req = 1'b0;
		rd_req      = 1'b0;
		wr_req      = 1'b0;
		rd_addr     = 4'h0;
	end

	// Kind 0 refresh, 1 read, 2 write; answer looked at once it has landed
	task automatic pulse(input int kind, input logic [3:0] addr, output logic ack, output logic [15:0] data);
		@(posedge clk);
		rd_addr     <= addr;
		refresh_req <= (kind == 0);
		rd_req      <= (kind == 1);
		wr_req      <= (kind == 2);
		@(posedge clk);
		refresh_req <= 1'b0;
		rd_req      <= 1'b0;
		wr_req      <= 1'b0;
		rd_addr     <= ~addr; // Stale address never lingers
		#1;
		ack  = (kind == 0) ? refresh_ack_reg : (kind == 1) ? rd_valid_reg : wr_refused_reg;
		data = rd_data_reg;
	endtask
endmodule

// ==== test/tb.sv ====
/*
  Self-checking bench for the status word bank, with the host model as partner.
  Assumes a 200 MHz clock and ce high except for one short freeze.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb;
	logic                           clk, sys_rst, ce, refresh_req, rd_req, wr_req, ack;
	logic                           refresh_ack_reg, rd_valid_reg, wr_refused_reg;
	logic [15:0]                    din_pins, dout_state, din_word_reg, dout_word_reg, axis_word_reg;
	logic [15:0]                    rd_data_reg, data, exp_ax;
	logic [1:0]                     fwd_lim_pins, rev_lim_pins;
	logic [3:0]                     rd_addr;
	mss_pkg::mss_axis_in_type [1:0] axis_in;
	int                             n_fail = 0;
	int                             cmp_count = 0;
	int                             cycles = 0;

	mss_status_words i_mss_status_words (.clk(clk), .sys_rst(sys_rst), .ce(ce), .din_pins(din_pins),
		.fwd_lim_pins(fwd_lim_pins), .rev_lim_pins(rev_lim_pins), .dout_state(dout_state), .axis_in(axis_in),
		.refresh_req(refresh_req), .rd_req(rd_req), .rd_addr(rd_addr), .wr_req(wr_req),
		.din_word_reg(din_word_reg), .dout_word_reg(dout_word_reg), .axis_word_reg(axis_word_reg),
		.refresh_ack_reg(refresh_ack_reg), .rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg),
		.wr_refused_reg(wr_refused_reg));
	mss_host_model i_mss_host_model (.clk(clk), .refresh_req(refresh_req), .rd_req(rd_req), .rd_addr(rd_addr),
		.wr_req(wr_req), .refresh_ack_reg(refresh_ack_reg), .rd_data_reg(rd_data_reg),
		.rd_valid_reg(rd_valid_reg), .wr_refused_reg(wr_refused_reg));

	// Clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Hang guard, far above the few hundred cycles needed
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_fail++;
			final_report();
		end
	end

	// Verdict
	task automatic final_report();
		if (n_fail == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Raise one flag condition, two for the hard limit; only the warning limit sits on the boundary otherwise
	task automatic set_flag(input int i);
		mss_pkg::mss_axis_in_type a [2];
		for (int k = 0; k < 2; k++) begin
			a[k] = '{32'sh0, 32'sh64, -32'sh64, 16'h32, 16'h32, 16'hc8, 1'b0, 1'b0};
		end
		case (i % 8)
			0: a[i / 8].ferr_mag = 16'h33;
			3: a[i / 8].homing = 1'b1;
			4: a[i / 8].feedhold = 1'b1;
			5: a[i / 8].ferr_mag = 16'hc9; // Past hard limit is past warning too
			6: a[i / 8].position = 32'sh65;
			7: a[i / 8].position = -32'sh65;
			default: ;
		endcase
		axis_in      <= {a[1], a[0]};
		fwd_lim_pins <= (i % 8 == 1) ? (2'h1 << (i / 8)) : 2'h0;
		rev_lim_pins <= (i % 8 == 2) ? (2'h1 << (i / 8)) : 2'h0;
		exp_ax = (16'h1 << i) | ((i % 8 == 5) ? (16'h1 << (i - 5)) : 16'h0);
	endtask

	// Refresh, then compare held words and their reads
	task automatic check_words(input logic [15:0] e_din, input logic [15:0] e_dout, input logic [15:0] e_ax);
		logic [15:0] e [3];
		e = '{e_din, e_dout, e_ax};
		i_mss_host_model.pulse(0, 4'h0, ack, data);
		`CHK(ack, 1'b1)
		`CHK({din_word_reg, dout_word_reg, axis_word_reg}, {e_din, e_dout, e_ax})
		for (int k = 0; k < 3; k++) begin
			i_mss_host_model.pulse(1, 4'h3 + k[3:0], ack, data);
			`CHK({ack, data}, {1'b1, e[k]})
		end
	endtask

	// Main sequence
	initial begin
		sys_rst      = 1'b1;
		ce           = 1'b1;
		din_pins     = 16'h0;
		dout_state   = 16'h0;
		fwd_lim_pins = 2'h0;
		rev_lim_pins = 2'h0;
		axis_in      = '0;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		// Walking one over every input and axis flag, walking zero over every output
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			din_pins   <= 16'h1 << i;
			dout_state <= ~(16'h1 << i);
			set_flag(i);
			repeat (4) @(posedge clk);
			check_words(16'h1 << i, ~(16'h1 << i), exp_ax);
		end
		// Held words ignore new sources and writes until the next refresh
		@(posedge clk);
		din_pins <= 16'ha5a5;
		repeat (4) @(posedge clk);
		i_mss_host_model.pulse(2, 4'h3, ack, data);
		`CHK(ack, 1'b1)
		i_mss_host_model.pulse(1, 4'h3, ack, data);
		`CHK(data, 16'h8000)
		check_words(16'ha5a5, 16'h7fff, 16'h8000);
		// Low enable freezes the bank: a refresh is ignored and the words hold
		@(posedge clk);
		ce       <= 1'b0;
		din_pins <= 16'h5a5a;
		i_mss_host_model.pulse(0, 4'h0, ack, data);
		`CHK({ack, din_word_reg}, {1'b0, 16'ha5a5})
		@(posedge clk);
		ce <= 1'b1;
		repeat (4) @(posedge clk);
		check_words(16'h5a5a, 16'h7fff, 16'h8000);
		// Unmapped offsets read as zero
		for (int k = 0; k < 16; k++) begin
			if (k < 3 || k > 5) begin
				i_mss_host_model.pulse(1, k[3:0], ack, data);
				`CHK({ack, data}, {1'b1, 16'h0})
			end
		end
		final_report();
	end
endmodule
